// ### pcs_pkg.sv
// Shared constants and types for the PC Card slot host port
//
// What this block does
// - Straps sampled once at reset release
// - Port active when select 111, alternate 1
// - Endian strap: 1 little, 0 big
// - Wait polarity strap: 1 high, 0 low
// - Wait driven always, or only when selected
// - Clock-divide strap halves bus clock rate
// - Sixteen-bit data bus toward the processor
// - ALE falling edge latches address 23:13
// - Card space select qualifies every access
// - Read on IO read or general read
// - Write on IO write or low write
// - Unused upper address and controls tied high
// - Two card selects steer the byte lanes
// - Device bytes cross onto host lanes 23:16/31:24
// - Wait until data ready; host extends cycle
// - Host strobes accepted asynchronously
// - Bus clock distinct from core clock
// - Lock bit 1 after reset; clearing unlocks
// - Attribute and IO cycles both answered
// - Registers and buffer alias every 2M
package pcs_pkg;

    // Strap field positions
    localparam int IFSEL_LSB   = 1;
    localparam int IFSEL_MSB   = 3;
    localparam int ENDIAN_BIT  = 4;
    localparam int WAITPOL_BIT = 5;
    localparam int ALT_BIT     = 11;
    localparam int CLKDIV_BIT  = 12;
    localparam int WAITDRV_BIT = 15;
    localparam logic [2:0]  IFSEL_PCCARD  = 3'h7;
    localparam logic [15:0] STRAP_SETTING = 16'h181E;
    localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

    // Device address map
    localparam int BUF_SEL_BIT = 23;
    localparam int REG_REV     = 0;
    localparam int REG_MISC    = 1;
    localparam int LOCK_BIT    = 7;
    localparam logic [7:0] MISC_RESET = 8'h80;

    // Host phase timing
    localparam int CLK_NS        = 8;
    localparam int PHASE_NS      = 32;
    localparam int PHASE_CYC     = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);

    // Host APB register offsets and fields
    localparam logic [7:0] HR_CTRL   = 8'h00;
    localparam logic [7:0] HR_ADDR   = 8'h04;
    localparam logic [7:0] HR_WDATA  = 8'h08;
    localparam logic [7:0] HR_RDATA  = 8'h0C;
    localparam logic [7:0] HR_STATUS = 8'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_IO    = 2;
    localparam int CTRL_BEH   = 3;
    localparam int CTRL_BEL   = 4;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_DONE  = 1;

    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_ARB  = 2'b01,
        DS_DONE = 2'b10
    } pcs_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE    = 3'b000,
        HS_ALE     = 3'b001,
        HS_HOLD    = 3'b010,
        HS_STROBE  = 3'b011,
        HS_WAIT    = 3'b100,
        HS_RECOVER = 3'b101
    } pcs_host_state_t;

endpackage

// ### pcs_if.sv
// Slot wiring between the slot controller and the display controller port
interface pcs_if;
    logic        upper_addr_latch_input;
    logic        card_space_select_n;
    logic        host_io_read_n;
    logic        host_io_write_n;
    logic        read_strobe_n;
    logic        low_write_enable_n;
    logic        host_high_byte_select_n;
    logic        host_low_byte_select_n;
    logic [12:0] addr;
    logic [3:0]  upper_addr_tie;
    logic        mem_reg_select;
    logic        chip_select_n;
    logic        bus_start_input;
    logic [15:0] config_straps;
    logic [31:0] host_d_o;
    logic        host_d_oe;
    logic [15:0] dev_d_o;
    logic        dev_d_oe;
    logic        wait_o;
    logic        wait_oe;
    logic [15:0] device_data_bus;
    logic [31:0] host_d_i;
    logic        host_wait_input;

    // Undriven lines read as pulled up
    assign device_data_bus = dev_d_oe ? dev_d_o
                           : host_d_oe ? {host_d_o[23:16], host_d_o[31:24]} : 16'hFFFF;
    assign host_d_i        = {device_data_bus[7:0], device_data_bus[15:8], 16'hFFFF};
    assign host_wait_input = wait_oe ? wait_o : 1'b1;

    modport dev (
        input  upper_addr_latch_input, card_space_select_n, host_io_read_n, host_io_write_n,
        input  read_strobe_n, low_write_enable_n, host_high_byte_select_n, host_low_byte_select_n,
        input  addr, upper_addr_tie, mem_reg_select, chip_select_n, bus_start_input,
        input  config_straps, device_data_bus,
        output dev_d_o, dev_d_oe, wait_o, wait_oe
    );

    modport host (
        output upper_addr_latch_input, card_space_select_n, host_io_read_n, host_io_write_n,
        output read_strobe_n, low_write_enable_n, host_high_byte_select_n, host_low_byte_select_n,
        output addr, upper_addr_tie, mem_reg_select, chip_select_n, bus_start_input,
        output config_straps, host_d_o, host_d_oe,
        input  host_d_i, host_wait_input
    );
endinterface

// ### pcs_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
module pcs_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### pcs_dev.sv
// Display controller end of the PC Card slot host port
module pcs_dev #(
    parameter int         REG_BYTES = 16,
    parameter int         BUF_WORDS = 64,
    parameter logic [7:0] REV_CODE  = 8'h5A // Value is arbitrary
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Slot pins
    pcs_if.dev        bus,
    // Display side
    input  wire logic refresh_busy,
    output logic      mode_active,
    output logic      little_endian,
    output logic      regs_locked
);
    import pcs_pkg::*;

    localparam int RI_W = $clog2(REG_BYTES);
    localparam int BI_W = $clog2(BUF_WORDS);
    localparam int SW   = 53;

    pcs_dev_state_t state;
    logic [15:0]    cfg;
    logic [1:0]     cfg_cnt;
    logic           cfg_taken;
    logic           div_tgl;
    logic           bus_en;
    logic [SW-1:0]  raw;
    logic [SW-1:0]  s;
    logic           s_ale;
    logic           s_cs_n;
    logic           s_iord_n;
    logic           s_iowr_n;
    logic           s_rd_n;
    logic           s_we_n;
    logic           s_hb_n;
    logic           s_lb_n;
    logic [12:0]    s_addr;
    logic [15:0]    s_db;
    logic [15:0]    s_straps;
    logic           ale_d;
    logic [10:0]    upper;
    logic [23:0]    full_addr;
    logic           buf_sel;
    logic [RI_W-1:1] ri;
    logic [BI_W-1:0] bi;
    logic           sel;
    logic           rd_req;
    logic           wr_req;
    logic           op_rd;
    logic           serve;
    logic           do_wr;
    logic [15:0]    wd;
    logic [1:0]     be;
    logic [15:0]    rd_val;
    logic           wait_req;
    logic [7:0]     regs [REG_BYTES];
    logic [15:0]    mem  [BUF_WORDS];

    function automatic logic [15:0] swap16(input logic [15:0] d, input logic le);
        swap16 = le ? d : {d[7:0], d[15:8]};
    endfunction

    function automatic logic [7:0] reg_byte(input logic [RI_W-1:0] k);
        if (k == RI_W'(REG_REV))
            reg_byte = REV_CODE;
        else if (regs_locked && k != RI_W'(REG_MISC))
            reg_byte = 8'h00;
        else
            reg_byte = regs[k];
    endfunction

    // Pins arrive unrelated to pclk, so every pin this end uses is retimed
    assign raw = {bus.config_straps, bus.upper_addr_latch_input, bus.card_space_select_n,
                  bus.host_io_read_n, bus.host_io_write_n, bus.read_strobe_n,
                  bus.low_write_enable_n, bus.host_high_byte_select_n,
                  bus.host_low_byte_select_n, bus.addr, bus.device_data_bus};

    // Latch strobe idles low; a high start would fake a falling edge after reset
    pcs_sync #(
        .W    (SW),
        .INIT ({16'hFFFF, 1'b0, 36'hFFFFFFFFF})
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw),
        .q       (s)
    );

    assign {s_straps, s_ale, s_cs_n, s_iord_n, s_iowr_n, s_rd_n, s_we_n,
            s_hb_n, s_lb_n, s_addr, s_db} = s;

    // Straps settle through the synchroniser, then are held until next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg       <= 16'h0000;
            cfg_cnt   <= 2'h0;
            cfg_taken <= 1'b0;
        end else if (!cfg_taken) begin
            cfg_cnt <= cfg_cnt + 2'h1;
            if (cfg_cnt == STRAP_SETTLE) begin
                cfg       <= s_straps;
                cfg_taken <= 1'b1;
            end
        end
    end

    assign mode_active   = cfg_taken && cfg[IFSEL_MSB:IFSEL_LSB] == IFSEL_PCCARD
                           && cfg[ALT_BIT];
    assign little_endian = cfg[ENDIAN_BIT];

    // pclk is the bus clock only; the core clock never reaches this port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_tgl <= 1'b0;
        else
            div_tgl <= ~div_tgl;
    end

    assign bus_en = !cfg[CLKDIV_BIT] || div_tgl;

    // Upper address capture on the falling latch strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_d <= 1'b0;
            upper <= 11'h000;
        end else if (bus_en) begin
            ale_d <= s_ale;
            if (ale_d && !s_ale)
                upper <= s_addr[10:0];
        end
    end

    // Bits 22:21 are not decoded, so each space repeats every 2M
    assign full_addr = {upper, s_addr};
    assign buf_sel   = full_addr[BUF_SEL_BIT];
    assign ri        = full_addr[RI_W-1:1];
    assign bi        = full_addr[BI_W:1];

    // Attribute and IO cycles look alike here
    assign sel    = mode_active && !s_cs_n;
    assign rd_req = sel && (!s_iord_n || !s_rd_n);
    assign wr_req = sel && (!s_iowr_n || !s_we_n);

    // Byte steering follows the endian strap
    assign wd = swap16(s_db, little_endian);
    assign be = little_endian ? {!s_hb_n, !s_lb_n} : {!s_lb_n, !s_hb_n};

    // Process form so a change of lock or register contents is seen at once
    always_comb begin
        rd_val = buf_sel ? mem[bi] : {reg_byte({ri, 1'b1}), reg_byte({ri, 1'b0})};
    end

    // Refresh owns the resources while busy; the host is held meanwhile
    assign serve = bus_en && state == DS_ARB && !refresh_busy;
    assign do_wr = serve && wr_req && !rd_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DS_IDLE;
            op_rd <= 1'b0;
        end else if (bus_en) begin
            unique case (state)
                DS_IDLE: begin
                    if (rd_req || wr_req)
                        state <= DS_ARB;
                end
                DS_ARB: begin
                    if (!rd_req && !wr_req)
                        state <= DS_IDLE;
                    else if (!refresh_busy) begin
                        op_rd <= rd_req;
                        state <= DS_DONE;
                    end
                end
                DS_DONE: begin
                    if (!rd_req && !wr_req)
                        state <= DS_IDLE;
                end
                default: state <= DS_IDLE;
            endcase
        end
    end

    // Read data is frozen on the same edge that drops wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bus.dev_d_o <= 16'h0000;
        else if (serve && rd_req)
            bus.dev_d_o <= swap16(rd_val, little_endian);
    end

    // Register bytes; the revision byte is read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < REG_BYTES; i++)
                regs[i] <= (i == REG_MISC) ? MISC_RESET : 8'h00;
        end else if (do_wr && !buf_sel) begin
            for (int i = 0; i < REG_BYTES; i++) begin
                if (i != REG_REV && (RI_W-1)'(i >> 1) == ri && be[i % 2]
                    && (!regs_locked || i == REG_MISC))
                    regs[i] <= (i % 2 == 1) ? wd[15:8] : wd[7:0];
            end
        end
    end

    assign regs_locked = regs[REG_MISC][LOCK_BIT];

    // Display buffer storage carries no reset
    always_ff @(posedge pclk) begin
        if (do_wr && buf_sel) begin
            if (be[1])
                mem[bi][15:8] <= wd[15:8];
            if (be[0])
                mem[bi][7:0] <= wd[7:0];
        end
    end

    assign wait_req     = (rd_req || wr_req) && state != DS_DONE;
    assign bus.wait_o   = cfg[WAITPOL_BIT] ? wait_req : !wait_req;
    assign bus.wait_oe  = mode_active && (cfg[WAITDRV_BIT] || sel);
    assign bus.dev_d_oe = state == DS_DONE && op_rd && rd_req;
endmodule

// ### pcs_host.sv
// Processor PC Card slot controller end, ordered over APB
module pcs_host (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Slot pins
    pcs_if.host              bus
);
    import pcs_pkg::*;

    pcs_host_state_t state;
    logic [3:0]      cnt;
    logic [23:0]     addr_r;
    logic [15:0]     wdata_r;
    logic [15:0]     rdata_r;
    logic            op_write;
    logic            op_io;
    logic            be_h;
    logic            be_l;
    logic            busy;
    logic            done;
    logic            wr_acc;
    logic            start;
    logic            fin;
    logic            wait_act;

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == HR_CTRL || a == HR_ADDR || a == HR_WDATA
                 || a == HR_RDATA || a == HR_STATUS;
    endfunction

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr_acc  = psel && penable && pwrite && mapped(paddr);
    assign start   = wr_acc && paddr == HR_CTRL && pwdata[CTRL_START] && !busy;
    assign fin     = state == HS_RECOVER && cnt == 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r   <= 24'h000000;
            wdata_r  <= 16'h0000;
            op_write <= 1'b0;
            op_io    <= 1'b0;
            be_h     <= 1'b1;
            be_l     <= 1'b1;
        end else if (wr_acc && !busy) begin
            if (paddr == HR_ADDR)
                addr_r <= pwdata[23:0];
            if (paddr == HR_WDATA)
                wdata_r <= pwdata[15:0];
            if (paddr == HR_CTRL) begin
                op_write <= pwdata[CTRL_WRITE];
                op_io    <= pwdata[CTRL_IO];
                be_h     <= pwdata[CTRL_BEH];
                be_l     <= pwdata[CTRL_BEL];
            end
        end
    end

    // A finishing transfer beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            if (start)
                busy <= 1'b1;
            else if (fin)
                busy <= 1'b0;
            if (fin)
                done <= 1'b1;
            else if (start || (wr_acc && paddr == HR_STATUS && pwdata[STAT_DONE]))
                done <= 1'b0;
        end
    end

    // Read data is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable) begin
            unique case (paddr)
                HR_CTRL:   prdata <= {27'h0, be_l, be_h, op_io, op_write, 1'b0};
                HR_ADDR:   prdata <= {8'h00, addr_r};
                HR_WDATA:  prdata <= {16'h0000, wdata_r};
                HR_RDATA:  prdata <= {16'h0000, rdata_r};
                HR_STATUS: prdata <= {30'h0, done, busy};
                default:   prdata <= 32'h00000000;
            endcase
        end
    end

    // Straps and unused controls are fixed by the board
    assign bus.config_straps   = STRAP_SETTING;
    assign bus.upper_addr_tie  = 4'hF;
    assign bus.mem_reg_select  = 1'b1;
    assign bus.chip_select_n   = 1'b1;
    assign bus.bus_start_input = 1'b1;

    assign wait_act = bus.host_wait_input == STRAP_SETTING[WAITPOL_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                       <= HS_IDLE;
            cnt                         <= 4'h0;
            rdata_r                     <= 16'h0000;
            bus.upper_addr_latch_input  <= 1'b0;
            bus.addr                    <= 13'h1FFF;
            bus.card_space_select_n     <= 1'b1;
            bus.host_io_read_n          <= 1'b1;
            bus.host_io_write_n         <= 1'b1;
            bus.read_strobe_n           <= 1'b1;
            bus.low_write_enable_n      <= 1'b1;
            bus.host_high_byte_select_n <= 1'b1;
            bus.host_low_byte_select_n  <= 1'b1;
            bus.host_d_o                <= 32'h00000000;
            bus.host_d_oe               <= 1'b0;
        end else begin
            if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
            unique case (state)
                HS_IDLE: begin
                    if (start) begin
                        bus.addr                   <= {2'b00, addr_r[23:13]};
                        bus.upper_addr_latch_input <= 1'b1;
                        cnt                        <= PHASE_LAST;
                        state                      <= HS_ALE;
                    end
                end
                HS_ALE: begin
                    if (cnt == 4'h0) begin
                        bus.upper_addr_latch_input <= 1'b0;
                        cnt                        <= PHASE_LAST;
                        state                      <= HS_HOLD;
                    end
                end
                HS_HOLD: begin
                    if (cnt == 4'h0) begin
                        bus.addr                    <= addr_r[12:0];
                        bus.card_space_select_n     <= 1'b0;
                        bus.host_high_byte_select_n <= !be_h;
                        bus.host_low_byte_select_n  <= !be_l;
                        bus.host_d_o  <= {wdata_r[7:0], wdata_r[15:8], 16'h0000};
                        bus.host_d_oe <= op_write;
                        if (op_io) begin
                            bus.host_io_read_n  <= op_write;
                            bus.host_io_write_n <= !op_write;
                        end else begin
                            bus.read_strobe_n      <= op_write;
                            bus.low_write_enable_n <= !op_write;
                        end
                        cnt   <= PHASE_LAST;
                        state <= HS_STROBE;
                    end
                end
                HS_STROBE: begin
                    if (cnt == 4'h0)
                        state <= HS_WAIT;
                end
                HS_WAIT: begin
                    if (!wait_act) begin
                        if (!op_write)
                            rdata_r <= {bus.host_d_i[23:16], bus.host_d_i[31:24]};
                        bus.card_space_select_n     <= 1'b1;
                        bus.host_io_read_n          <= 1'b1;
                        bus.host_io_write_n         <= 1'b1;
                        bus.read_strobe_n           <= 1'b1;
                        bus.low_write_enable_n      <= 1'b1;
                        bus.host_high_byte_select_n <= 1'b1;
                        bus.host_low_byte_select_n  <= 1'b1;
                        bus.host_d_oe               <= 1'b0;
                        cnt                         <= PHASE_LAST;
                        state                       <= HS_RECOVER;
                    end
                end
                HS_RECOVER: begin
                    if (cnt == 4'h0)
                        state <= HS_IDLE;
                end
                default: state <= HS_IDLE;
            endcase
        end
    end
endmodule

// ### pcs_asserts.sv
// Concurrent checks on the slot wiring between host and device ends
module pcs_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host strobes
    input wire logic card_space_select_n,
    input wire logic host_io_read_n,
    input wire logic read_strobe_n,
    input wire logic host_io_write_n,
    input wire logic low_write_enable_n,
    input wire logic host_d_oe,
    // Device drive
    input wire logic dev_d_oe,
    input wire logic wait_o,
    input wire logic wait_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Straps give an active-low wait
    wire waiting = wait_oe && !wait_o;
    sequence s_rd_req;
        !card_space_select_n && $fell(host_io_read_n && read_strobe_n);
    endsequence
    sequence s_wr_req;
        !card_space_select_n && $fell(host_io_write_n && low_write_enable_n);
    endsequence
    a_wait_floats: assert property (card_space_select_n [*4] |-> !wait_oe)
        else $error("wait driven while unselected");
    a_wait_on_read: assert property (s_rd_req |-> ##[1:4] waiting)
        else $error("no wait after read strobe");
    a_wait_on_write: assert property (s_wr_req |-> ##[1:4] waiting)
        else $error("no wait after write strobe");
    a_wait_bounded: assert property ($rose(waiting) |-> ##[1:400] !waiting)
        else $error("wait never released");
    a_wait_needs_sel: assert property (waiting |-> !card_space_select_n)
        else $error("wait while host released");
    a_host_ends: assert property ($fell(waiting) |-> ##[1:8] card_space_select_n)
        else $error("host kept cycle after wait");
    a_rd_release: assert property ((host_io_read_n && read_strobe_n) [*4] |-> !dev_d_oe)
        else $error("data driven without read");
    a_no_clash: assert property (!(dev_d_oe && host_d_oe))
        else $error("both ends drive data");
endmodule

// ### pcs_tb.sv
// Self-checking bench joining host and device ends over the slot
module pcs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    logic        pclk, presetn, refresh_busy, psel, penable, pwrite, pready, pslverr, last_err;
    logic        mode_active, little_endian, regs_locked, wr, io;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, t;
    logic [15:0] mem [16];
    logic [15:0] r, d;
    logic [23:0] a;
    logic [1:0]  ln;
    int          idx;
    int          error_cnt = 0;
    int          n_compared = 0;
    pcs_if bus_if ();
    pcs_host u_pcs_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
    pcs_dev u_pcs_dev (.pclk(pclk), .presetn(presetn), .bus(bus_if), .refresh_busy(refresh_busy),
        .mode_active(mode_active), .little_endian(little_endian), .regs_locked(regs_locked));
    pcs_asserts u_chk (.pclk(pclk), .presetn(presetn), .card_space_select_n(bus_if.card_space_select_n),
        .host_io_read_n(bus_if.host_io_read_n), .read_strobe_n(bus_if.read_strobe_n),
        .host_io_write_n(bus_if.host_io_write_n), .low_write_enable_n(bus_if.low_write_enable_n),
        .host_d_oe(bus_if.host_d_oe), .dev_d_oe(bus_if.dev_d_oe), .wait_o(bus_if.wait_o),
        .wait_oe(bus_if.wait_oe));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Random refresh contention stretches some waits
    always @(posedge pclk) refresh_busy <= presetn && ($urandom_range(3) == 0);
    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic beh, logic bel);
        return {beh ? n[15:8] : o[15:8], bel ? n[7:0] : o[7:0]};
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Idle edge first so psel never gets two values in one step
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic acc(logic w, logic i, logic beh, logic bel, logic [23:0] ad, logic [15:0] wd,
                       output logic [15:0] rd);
        int n;
        apb(1'b1, HR_ADDR, {8'h00, ad}, t);
        apb(1'b1, HR_WDATA, {16'h0000, wd}, t);
        apb(1'b1, HR_CTRL, {27'h0, bel, beh, i, w, 1'b1}, t);
        n = 0;
        do begin
            apb(1'b0, HR_STATUS, 32'h0, t);
            n++;
        end while (t[STAT_DONE] !== 1'b1 && n < 200);
        chk("slot done", 32'h1, {31'h0, t[STAT_DONE]});
        apb(1'b0, HR_RDATA, 32'h0, t);
        rd = t[15:0];
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen timeout");
        stop_test();
    end
    initial begin
        void'($urandom(27738));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        refresh_busy = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("mode", 32'h1, {31'h0, mode_active});
        chk("endian", 32'h1, {31'h0, little_endian});
        chk("locked", 32'h1, {31'h0, regs_locked});
        $display("test straps done");
        acc(1'b0, 1'b0, 1'b1, 1'b1, 24'h000000, 16'h0000, r);
        chk("rev word", {16'h0000, MISC_RESET, 8'h5A}, {16'h0000, r});
        acc(1'b0, 1'b1, 1'b1, 1'b1, 24'h600000, 16'h0000, r);
        chk("rev alias", {16'h0000, MISC_RESET, 8'h5A}, {16'h0000, r});
        acc(1'b1, 1'b0, 1'b0, 1'b1, 24'h000000, 16'h00FF, r);
        acc(1'b1, 1'b1, 1'b1, 1'b1, 24'h000004, 16'hA5A5, r);
        acc(1'b0, 1'b0, 1'b1, 1'b1, 24'h000004, 16'h0000, r);
        chk("locked reg", 32'h0, {16'h0000, r});
        acc(1'b1, 1'b1, 1'b1, 1'b0, 24'h200000, 16'h0000, r);
        chk("unlock", 32'h0, {31'h0, regs_locked});
        acc(1'b0, 1'b0, 1'b1, 1'b1, 24'h000000, 16'h0000, r);
        chk("rev ro", 32'h005A, {16'h0000, r});
        acc(1'b1, 1'b0, 1'b1, 1'b1, 24'h000004, 16'hA5A5, r);
        acc(1'b0, 1'b1, 1'b1, 1'b1, 24'h000004, 16'h0000, r);
        chk("open reg", 32'hA5A5, {16'h0000, r});
        apb(1'b0, 8'h14, 32'h0, t);
        chk("unmapped", 32'h1, {31'h0, last_err});
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'($urandom);
            acc(1'b1, i[0], 1'b1, 1'b1, 24'h800000 | 24'(i * 2), mem[i], r);
        end
        for (int k = 0; k < 40; k++) begin
            idx = $urandom_range(15);
            wr = 1'($urandom);
            io = 1'($urandom);
            ln = 2'($urandom_range(3, 1));
            d = 16'($urandom);
            a = 24'h800000 | {1'b0, 2'($urandom_range(3)), 21'h0} | 24'(idx * 2);
            if (wr) begin
                acc(1'b1, io, ln[1], ln[0], a, d, r);
                mem[idx] = merge(mem[idx], d, ln[1], ln[0]);
            end else begin
                acc(1'b0, io, 1'b1, 1'b1, a, 16'h0000, r);
                chk("buffer", {16'h0000, mem[idx]}, {16'h0000, r});
            end
        end
        $display("test buffer done");
        stop_test();
    end
endmodule
